// ==== hdl/mip_bank.sv ====
// Microcontroller I/O port bank: analog input port and four bidirectional ports
`timescale 1ns/1ps
`include "mip_cfg.svh"
module mip_bank #(
    parameter int AN_W = `MIP_AN_W
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // CPU register access
    input wire logic [15:0] cpu_addr,
    input wire logic cpu_addr16,
    input wire logic cpu_wr,
    input wire logic cpu_rd,
    input wire logic [7:0] cpu_wdata,
    output logic [7:0] cpu_rdata,
    output logic cpu_rvalid,
    output logic cpu_busy,
    // Analog-shared input-only pins
    input wire logic [AN_W-1:0] an_pin_in,
    // Bidirectional pins, index 0..3 = port 1, 2, 5, 6
    input wire logic [`MIP_NPORTS*8-1:0] pin_in,
    output logic [`MIP_NPORTS*8-1:0] pin_out,
    output logic [`MIP_NPORTS*8-1:0] pin_oe,
    output logic [`MIP_NPORTS*8-1:0] pin_weak_hold,
    // Peripheral signals for special-function mode
    input wire logic [`MIP_NPORTS*8-1:0] peripheral_direction_signal,
    input wire logic [`MIP_NPORTS*8-1:0] peripheral_data_signal
);
    import mip_pkg::*;

    // ==========================================================
    // Parameter check
    if (AN_W < 1 || AN_W > 8) begin : g_bad_an
        $error("analog port width must be 1 to 8");
    end

    localparam logic [15:0] MODE_OFS [`MIP_NPORTS] = '{`MIP_PORT_ONE_FUNCTION_SELECT_OFS, `MIP_PORT_TWO_FUNCTION_SELECT_OFS,
                                                        `MIP_PORT_FIVE_FUNCTION_SELECT_OFS, `MIP_PORT_SIX_FUNCTION_SELECT_OFS};
    localparam logic [15:0] DIR_OFS [`MIP_NPORTS] = '{`MIP_PORT_ONE_DIRECTION_OFS, `MIP_PORT_TWO_DIRECTION_OFS,
                                                       `MIP_PORT_FIVE_DIRECTION_OFS, `MIP_PORT_SIX_DIRECTION_OFS};
    localparam logic [15:0] ODATA_OFS [`MIP_NPORTS] = '{`MIP_P1_ODATA_OFS, `MIP_P2_ODATA_OFS,
                                                         `MIP_P5_ODATA_OFS, `MIP_P6_ODATA_OFS};
    localparam logic [15:0] PIN_OFS [`MIP_NPORTS] = '{`MIP_PORT_ONE_PIN_STATE_OFS, `MIP_PORT_TWO_PIN_STATE_OFS,
                                                       `MIP_PORT_FIVE_PIN_STATE_OFS, `MIP_PORT_SIX_PIN_STATE_OFS};

    // ==========================================================
    // Address decode
    // Port five sits in memory-mapped space: an 8-bit or windowed access misses it
    function automatic mip_sel_type decode(input logic [15:0] a, input logic a16);
        mip_sel_type s;
        s.kind = MIP_K_NONE;
        s.idx = 2'h0;
        if (a == `MIP_AN_PIN_OFS) begin
            s.kind = MIP_K_AN;
        end
        for (int i = 0; i < `MIP_NPORTS; i++) begin
            if (a == MODE_OFS[i]) begin
                s.kind = MIP_K_MODE;
                s.idx = 2'(i);
            end else if (a == DIR_OFS[i]) begin
                s.kind = MIP_K_DIR;
                s.idx = 2'(i);
            end else if (a == ODATA_OFS[i]) begin
                s.kind = MIP_K_ODATA;
                s.idx = 2'(i);
            end else if (a == PIN_OFS[i]) begin
                s.kind = MIP_K_PIN;
                s.idx = 2'(i);
            end
        end
        if (s.idx == `MIP_P5_IDX && s.kind != MIP_K_AN && !a16) begin
            s.kind = MIP_K_NONE;
        end
        return s;
    endfunction

    mip_sel_type sel;
    assign sel = decode(cpu_addr, cpu_addr16);

    // ==========================================================
    // Configuration registers
    logic [7:0] mode_q [`MIP_NPORTS];
    logic [7:0] mode_d [`MIP_NPORTS];
    logic [7:0] dir_q [`MIP_NPORTS];
    logic [7:0] dir_d [`MIP_NPORTS];
    logic [7:0] odata_q [`MIP_NPORTS];
    logic [7:0] odata_d [`MIP_NPORTS];
    logic [`MIP_NPORTS-1:0] hold_q;
    logic [`MIP_NPORTS-1:0] hold_d;

    always_comb begin
        mode_d = mode_q;
        dir_d = dir_q;
        odata_d = odata_q;
        hold_d = hold_q;
        if (cpu_wr) begin
            case (sel.kind)
                MIP_K_MODE: begin
                    mode_d[sel.idx] = cpu_wdata;
                    hold_d[sel.idx] = 1'b0;
                end
                MIP_K_DIR: dir_d[sel.idx] = cpu_wdata;
                MIP_K_ODATA: odata_d[sel.idx] = cpu_wdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < `MIP_NPORTS; i++) begin
                mode_q[i] <= `MIP_MODE_RST;
                dir_q[i] <= `MIP_DIR_RST;
                odata_q[i] <= `MIP_ODATA_RST;
            end
            hold_q <= '1;
        end else begin
            mode_q <= mode_d;
            dir_q <= dir_d;
            odata_q <= odata_d;
            hold_q <= hold_d;
        end
    end

    // ==========================================================
    // Bidirectional ports
    logic [7:0] state [`MIP_NPORTS];

    for (genvar p = 0; p < `MIP_NPORTS; p++) begin : g_port
        mip_pin_if #(.W(8)) pif ();
        assign pif.dir = dir_q[p];
        assign pif.mode = mode_q[p];
        assign pif.odata = odata_q[p];
        assign pif.sf_dir = peripheral_direction_signal[p*8 +: 8];
        assign pif.sf_data = peripheral_data_signal[p*8 +: 8];
        assign pif.hold = hold_q[p];
        assign state[p] = pif.state;
        mip_port_drv #(.W(8)) u_drv (
            .sys_clk(sys_clk),
            .resetn(resetn),
            .cfg(pif.pin),
            .pin_in(pin_in[p*8 +: 8]),
            .pin_out(pin_out[p*8 +: 8]),
            .pin_oe(pin_oe[p*8 +: 8]),
            .pin_weak_hold(pin_weak_hold[p*8 +: 8])
        );
    end

    // ==========================================================
    // Read sequence
    // The analog sample register is only clocked in the sample state of an analog
    // read, so the converter sees no digital switching between reads
    mip_rd_type rd_q;
    mip_rd_type rd_d;
    mip_sel_type rsel_q;
    mip_sel_type rsel_d;
    logic [AN_W-1:0] an_sample_q;
    logic [AN_W-1:0] an_sample_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic rvalid_q;
    logic rvalid_d;

    always_comb begin
        rd_d = rd_q;
        rsel_d = rsel_q;
        an_sample_d = an_sample_q;
        rdata_d = rdata_q;
        rvalid_d = 1'b0;
        case (rd_q)
            MIP_RD_IDLE: begin
                if (cpu_rd) begin
                    rsel_d = sel;
                    rd_d = MIP_RD_SAMPLE;
                end
            end
            MIP_RD_SAMPLE: begin
                if (rsel_q.kind == MIP_K_AN) begin
                    an_sample_d = an_pin_in;
                end
                rd_d = MIP_RD_ANSWER;
            end
            MIP_RD_ANSWER: begin
                rvalid_d = 1'b1;
                rd_d = MIP_RD_IDLE;
                case (rsel_q.kind)
                    MIP_K_MODE: rdata_d = mode_q[rsel_q.idx];
                    MIP_K_DIR: rdata_d = dir_q[rsel_q.idx];
                    MIP_K_ODATA: rdata_d = odata_q[rsel_q.idx];
                    MIP_K_PIN: rdata_d = state[rsel_q.idx];
                    MIP_K_AN: rdata_d = 8'(an_sample_q);
                    default: rdata_d = 8'h00;
                endcase
            end
            default: rd_d = MIP_RD_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rd_q <= MIP_RD_IDLE;
            rsel_q <= '{kind: MIP_K_NONE, idx: 2'h0};
            an_sample_q <= '0;
            rdata_q <= 8'h00;
            rvalid_q <= 1'b0;
        end else begin
            rd_q <= rd_d;
            rsel_q <= rsel_d;
            an_sample_q <= an_sample_d;
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    assign cpu_rdata = rdata_q;
    assign cpu_rvalid = rvalid_q;
    assign cpu_busy = (rd_q != MIP_RD_IDLE);

    // ==========================================================
    // Checks
    default clocking dc @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    an_sample_quiet_a: assert property (!(rd_q == MIP_RD_SAMPLE && rsel_q.kind == MIP_K_AN) |=> $stable(an_sample_q))
        else $error("analog sample register clocked outside an analog read");
    an_read_value_a: assert property (rd_q == MIP_RD_SAMPLE && rsel_q.kind == MIP_K_AN |=> ##1 cpu_rvalid && cpu_rdata == 8'($past(an_pin_in, 2)))
        else $error("analog read does not return pin level sampled a state earlier");
    read_latency_a: assert property (cpu_rd && !cpu_busy |=> !cpu_rvalid ##1 !cpu_rvalid ##1 cpu_rvalid)
        else $error("read answer not three cycles after request");
    hold_release_a: assert property (cpu_wr && sel.kind == MIP_K_MODE |=> !hold_q[$past(sel.idx)])
        else $error("weak hold not released by function select write");
    hold_keep_a: assert property (!(cpu_wr && sel.kind == MIP_K_MODE) |=> hold_q == $past(hold_q))
        else $error("weak hold changed without function select write");
    dir_write_a: assert property (cpu_wr && sel.kind == MIP_K_DIR |=> dir_q[$past(sel.idx)] == $past(cpu_wdata))
        else $error("direction write not stored");
    p5_window_a: assert property (cpu_wr && !cpu_addr16 && cpu_addr == `MIP_PORT_FIVE_FUNCTION_SELECT_OFS |=> $stable(mode_q[2]) && hold_q[2] == $past(hold_q[2]))
        else $error("port five written without 16-bit access");
    odata_periph_a: assert property (cpu_wr && sel.kind == MIP_K_ODATA |=> odata_q[$past(sel.idx)] == $past(cpu_wdata))
        else $error("output data write not stored");

    an_read_c: cover property (cpu_rd && !cpu_busy && sel.kind == MIP_K_AN ##3 cpu_rvalid);
    p5_read16_c: cover property (cpu_rd && !cpu_busy && sel.kind == MIP_K_PIN && sel.idx == `MIP_P5_IDX);
    hold_drop_c: cover property (hold_q[0] ##1 !hold_q[0]);
    periph_mode_c: cover property (mode_q[1] != 8'h00 && pin_oe[15:8] != 8'h00);
endmodule

// ==== hdl/mip_cfg.svh ====
// Constants for the microcontroller I/O port bank
//
// Functional notes
// - Analog port is eight input-only pins, undriven
// - Analog port state register reads pin levels
// - Analog sample register clocks only on reads
// - Analog pin sampled one state before answer
// - Analog pins readable while converter uses them
// - Direction 0 complementary, 1 input/open-drain
// - Function select 0 I/O, 1 peripheral
// - Pin state reads pins in every configuration
// - Direction, function select, output data are read/write
// - Output data reaches pin at once in I/O
// - Peripheral owns pin; data stored, not driven
// - Port five needs 16-bit access, never windowed
// - Weak hold high until function select written
// - Peripheral mode uses peripheral direction and data
// - Open-drain drives low on 0, floats on 1
`ifndef MIP_CFG_SVH
`define MIP_CFG_SVH

// ==========================================================
// Register offsets
`define MIP_PORT_TWO_FUNCTION_SELECT_OFS 16'h1fc9
`define MIP_PORT_TWO_DIRECTION_OFS 16'h1fcb
`define MIP_P2_ODATA_OFS 16'h1fcd
`define MIP_PORT_TWO_PIN_STATE_OFS 16'h1fcf
`define MIP_PORT_ONE_FUNCTION_SELECT_OFS 16'h1fd0
`define MIP_PORT_SIX_FUNCTION_SELECT_OFS 16'h1fd1
`define MIP_PORT_ONE_DIRECTION_OFS 16'h1fd2
`define MIP_PORT_SIX_DIRECTION_OFS 16'h1fd3
`define MIP_P1_ODATA_OFS 16'h1fd4
`define MIP_P6_ODATA_OFS 16'h1fd5
`define MIP_PORT_ONE_PIN_STATE_OFS 16'h1fd6
`define MIP_PORT_SIX_PIN_STATE_OFS 16'h1fd7
`define MIP_AN_PIN_OFS 16'h1fda
`define MIP_PORT_FIVE_FUNCTION_SELECT_OFS 16'h1ff1
`define MIP_PORT_FIVE_DIRECTION_OFS 16'h1ff3
`define MIP_P5_ODATA_OFS 16'h1ff5
`define MIP_PORT_FIVE_PIN_STATE_OFS 16'h1ff7

// ==========================================================
// Port indices and reset values
`define MIP_NPORTS 4
`define MIP_P5_IDX 2'h2
`define MIP_MODE_RST 8'h00
`define MIP_DIR_RST 8'hff
`define MIP_ODATA_RST 8'hff
`define MIP_AN_W 8

`endif

// ==== hdl/mip_pkg.sv ====
// Types shared by the I/O port bank modules
package mip_pkg;
    typedef enum {
        MIP_K_NONE,
        MIP_K_MODE,
        MIP_K_DIR,
        MIP_K_ODATA,
        MIP_K_PIN,
        MIP_K_AN
    } mip_kind_type;

    typedef struct packed {
        mip_kind_type kind;
        logic [1:0] idx;
    } mip_sel_type;

    typedef enum {
        MIP_RD_IDLE,
        MIP_RD_SAMPLE,
        MIP_RD_ANSWER
    } mip_rd_type;
endpackage

// ==== hdl/mip_pin_if.sv ====
// Per-port configuration and pin-state carrier
`timescale 1ns/1ps
interface mip_pin_if #(parameter int W = 8);
    logic [W-1:0] dir;
    logic [W-1:0] mode;
    logic [W-1:0] odata;
    logic [W-1:0] sf_dir;
    logic [W-1:0] sf_data;
    logic [W-1:0] state;
    logic hold;
    modport ctrl (output dir, output mode, output odata, output sf_dir, output sf_data, output hold, input state);
    modport pin (input dir, input mode, input odata, input sf_dir, input sf_data, input hold, output state);
endinterface

// ==== hdl/mip_port_drv.sv ====
// One bidirectional port: pin driver and input synchroniser
`timescale 1ns/1ps
module mip_port_drv #(
    parameter int W = 8
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Configuration and state
    mip_pin_if.pin cfg,
    // Pins
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] pin_out,
    output logic [W-1:0] pin_oe,
    output logic [W-1:0] pin_weak_hold
);
    import mip_pkg::*;

    // ==========================================================
    // Parameter check
    if (W < 1 || W > 8) begin : g_bad_w
        $error("port width must be 1 to 8");
    end

    // ==========================================================
    // Driver
    logic [W-1:0] eff_dir;
    logic [W-1:0] eff_data;
    logic [W-1:0] sync1_q;
    logic [W-1:0] sync1_d;
    logic [W-1:0] sync2_q;
    logic [W-1:0] sync2_d;

    always_comb begin
        eff_dir = (cfg.mode & cfg.sf_dir) | (~cfg.mode & cfg.dir);
        eff_data = (cfg.mode & cfg.sf_data) | (~cfg.mode & cfg.odata);
        pin_oe = ~eff_dir | ~eff_data;
        pin_out = eff_data & ~eff_dir;
        pin_weak_hold = {W{cfg.hold}};
    end

    // ==========================================================
    // Synchroniser; state reads regardless of configuration
    always_comb begin
        sync1_d = pin_in;
        sync2_d = sync1_q;
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= sync1_d;
            sync2_q <= sync2_d;
        end
    end

    assign cfg.state = sync2_q;

    // ==========================================================
    // Checks
    default clocking dc @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    io_comp_drive_a: assert property (cfg.mode == '0 && cfg.dir == '0 |-> pin_oe == '1 && pin_out == cfg.odata)
        else $error("complementary I/O pin not driving output data");
    open_drain_a: assert property (cfg.mode == '0 && cfg.dir == '1 |-> pin_oe == ~cfg.odata && pin_out == '0)
        else $error("open-drain pin drive wrong");
    periph_own_a: assert property (cfg.mode == '1 |-> pin_oe == (~cfg.sf_dir | ~cfg.sf_data))
        else $error("peripheral mode not using peripheral direction and data");
    sync_delay_a: assert property (##2 1'b1 |-> cfg.state == $past(pin_in, 2))
        else $error("pin state not two cycles behind pin");
endmodule

// ==== bench/mip_sys_model.sv ====
// Board-side model of the circuitry wired to the bidirectional port pins
`timescale 1ns/1ps
module mip_sys_model (
    // Device pin drive
    input wire logic [31:0] pin_out,
    input wire logic [31:0] pin_oe,
    // Board drivers set by the test
    input wire logic [31:0] ext_en,
    input wire logic [31:0] ext_val,
    // Resolved pin levels
    output logic [31:0] pin_lvl
);
    // ==========================================================
    // Pin resolution
    // Device drive wins; tests never let both sides drive one pin
    // Undriven pins rest high: open-drain lines rely on board pull-ups
    always_comb begin
        for (int i = 0; i < 32; i++) begin
            if (pin_oe[i]) begin
                pin_lvl[i] = pin_out[i];
            end else if (ext_en[i]) begin
                pin_lvl[i] = ext_val[i];
            end else begin
                pin_lvl[i] = 1'b1;
            end
        end
    end
endmodule

// ==== bench/mip_bank_tb_top.sv ====
// Self-checking testbench for the I/O port bank
`timescale 1ns/1ps
`include "mip_cfg.svh"
module mip_bank_tb_top;
    // ==========================================================
    // Signals
    logic sys_clk, resetn, cpu_addr16, cpu_wr, cpu_rd, cpu_rvalid, cpu_busy;
    logic [15:0] cpu_addr;
    logic [7:0] cpu_wdata, cpu_rdata, an_pin;
    logic [31:0] pin_lvl, pin_out, pin_oe, pin_weak_hold, per_dir, per_data, ext_en, ext_val;
    logic [7:0] d, o, e;
    int err_total = 0;
    int n_tests = 0;
    logic [15:0] mode_ofs [4] = '{`MIP_PORT_ONE_FUNCTION_SELECT_OFS, `MIP_PORT_TWO_FUNCTION_SELECT_OFS, `MIP_PORT_FIVE_FUNCTION_SELECT_OFS, `MIP_PORT_SIX_FUNCTION_SELECT_OFS};
    logic [15:0] dir_ofs [4] = '{`MIP_PORT_ONE_DIRECTION_OFS, `MIP_PORT_TWO_DIRECTION_OFS, `MIP_PORT_FIVE_DIRECTION_OFS, `MIP_PORT_SIX_DIRECTION_OFS};
    logic [15:0] od_ofs [4] = '{`MIP_P1_ODATA_OFS, `MIP_P2_ODATA_OFS, `MIP_P5_ODATA_OFS, `MIP_P6_ODATA_OFS};
    logic [15:0] pin_ofs [4] = '{`MIP_PORT_ONE_PIN_STATE_OFS, `MIP_PORT_TWO_PIN_STATE_OFS, `MIP_PORT_FIVE_PIN_STATE_OFS, `MIP_PORT_SIX_PIN_STATE_OFS};

    // ==========================================================
    // Design and board model
    mip_bank dut (
        .sys_clk(sys_clk), .resetn(resetn), .cpu_addr(cpu_addr), .cpu_addr16(cpu_addr16),
        .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
        .cpu_rvalid(cpu_rvalid), .cpu_busy(cpu_busy), .an_pin_in(an_pin), .pin_in(pin_lvl),
        .pin_out(pin_out), .pin_oe(pin_oe), .pin_weak_hold(pin_weak_hold),
        .peripheral_direction_signal(per_dir), .peripheral_data_signal(per_data)
    );
    mip_sys_model board (
        .pin_out(pin_out), .pin_oe(pin_oe), .ext_en(ext_en), .ext_val(ext_val), .pin_lvl(pin_lvl)
    );

    always #4 sys_clk = ~sys_clk;

    // ==========================================================
    // Tasks
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic w16, input logic [7:0] v);
        @(negedge sys_clk);
        cpu_addr = a;
        cpu_addr16 = w16;
        cpu_wdata = v;
        cpu_wr = 1'b1;
        @(negedge sys_clk);
        cpu_wr = 1'b0;
    endtask

    // Reads are never overlapped, so each sees its own answer
    task automatic rd(input logic [15:0] a, input logic w16, input logic [7:0] exp);
        int n;
        // The edge that takes the request is cycle one of the count
        n = 1;
        @(negedge sys_clk);
        cpu_addr = a;
        cpu_addr16 = w16;
        cpu_rd = 1'b1;
        @(negedge sys_clk);
        cpu_rd = 1'b0;
        chk("read busy", {31'h0, cpu_busy}, 32'h1);
        while (cpu_rvalid !== 1'b1 && n < 8) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        chk("read latency", 32'(n), 32'd3);
        chk("read data", {24'h0, cpu_rdata}, {24'h0, exp});
    endtask

    task automatic results();
        $display("Comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Generous bound: the sequence needs well under a thousand cycles
    initial begin
        #100000;
        err_total++;
        results();
    end

    // ==========================================================
    // Test sequence
    initial begin
        sys_clk = 1'b0;
        resetn = 1'b0;
        cpu_addr = 16'h0000;
        cpu_addr16 = 1'b0;
        cpu_wr = 1'b0;
        cpu_rd = 1'b0;
        cpu_wdata = 8'h00;
        an_pin = 8'h00;
        per_dir = 32'hffffffff;
        per_data = 32'hffffffff;
        ext_en = 32'h00000000;
        ext_val = 32'h00000000;
        repeat (5) @(negedge sys_clk);
        resetn = 1'b1;
        @(negedge sys_clk);
        chk("weak hold after reset", pin_weak_hold, 32'hffffffff);
        chk("drive after reset", pin_oe, 32'h00000000);
        for (int p = 0; p < 4; p++) begin
            rd(mode_ofs[p], 1'b1, `MIP_MODE_RST);
            rd(dir_ofs[p], 1'b1, `MIP_DIR_RST);
            rd(od_ofs[p], 1'b1, `MIP_ODATA_RST);
        end
        // Port five without 16-bit addressing behaves as unmapped
        wr(`MIP_PORT_FIVE_FUNCTION_SELECT_OFS, 1'b0, 8'h00);
        chk("hold kept on short access", pin_weak_hold, 32'hffffffff);
        wr(`MIP_PORT_FIVE_DIRECTION_OFS, 1'b0, 8'h00);
        rd(`MIP_PORT_FIVE_DIRECTION_OFS, 1'b0, 8'h00);
        rd(`MIP_PORT_FIVE_DIRECTION_OFS, 1'b1, `MIP_DIR_RST);
        // Any function-select write drops that port's hold only
        wr(mode_ofs[0], 1'b1, 8'h00);
        chk("hold released port one", pin_weak_hold, 32'hffffff00);
        // Mixed complementary and open-drain outputs on every port
        for (int p = 0; p < 4; p++) begin
            d = 8'h1f;
            o = 8'h93;
            wr(mode_ofs[p], 1'b1, 8'h00);
            wr(dir_ofs[p], 1'b1, d);
            wr(od_ofs[p], 1'b1, o);
            chk("drive enable", 32'(pin_oe[p*8 +: 8]), 32'(8'(~d | ~o)));
            chk("drive value", 32'(pin_out[p*8 +: 8]), 32'(o & ~d));
            rd(mode_ofs[p], 1'b1, 8'h00);
            rd(dir_ofs[p], 1'b1, d);
            rd(od_ofs[p], 1'b1, o);
            rd(pin_ofs[p], 1'b1, o);
        end
        chk("hold released all", pin_weak_hold, 32'h00000000);
        // Port two handed to its peripheral
        per_dir[15:8] = 8'h0f;
        per_data[15:8] = 8'h35;
        wr(mode_ofs[1], 1'b1, 8'hff);
        chk("peripheral enable", 32'(pin_oe[15:8]), 32'(8'(~8'h0f | ~8'h35)));
        chk("peripheral value", 32'(pin_out[15:8]), 32'(8'h35 & ~8'h0f));
        wr(od_ofs[1], 1'b1, 8'h00);
        chk("stored data not driven", 32'(pin_out[15:8]), 32'(8'h35 & ~8'h0f));
        rd(od_ofs[1], 1'b1, 8'h00);
        wr(mode_ofs[1], 1'b1, 8'h00);
        chk("stored data enable", 32'(pin_oe[15:8]), 32'hff);
        chk("stored data value", 32'(pin_out[15:8]), 32'h00);
        // Port six as plain inputs driven from the board
        wr(dir_ofs[3], 1'b1, 8'hff);
        wr(od_ofs[3], 1'b1, 8'hff);
        ext_en[31:24] = 8'hff;
        ext_val[31:24] = 8'hc3;
        chk("input not driven", 32'(pin_oe[31:24]), 32'h00);
        rd(pin_ofs[3], 1'b1, 8'hc3);
        // Analog-shared port; no conversion runs during these reads
        an_pin = 8'ha5;
        rd(`MIP_AN_PIN_OFS, 1'b0, 8'ha5);
        wr(`MIP_AN_PIN_OFS, 1'b1, 8'h00);
        an_pin = 8'h5a;
        rd(`MIP_AN_PIN_OFS, 1'b1, 8'h5a);
        // State registers ignore writes; holes read zero
        wr(pin_ofs[0], 1'b1, 8'h00);
        rd(pin_ofs[0], 1'b1, 8'h93);
        rd(16'h1fd8, 1'b1, 8'h00);
        results();
    end
endmodule
